// ---- rtl/usw_pkg.sv ----
// usw_pkg: constants, register map and carrier types of the 8/9-bit serial
// channel with multiprocessor wakeup and infrared modem.
// assumes one 250 MHz system clock and an AXI4-Lite master for registers.
// Notes on behaviour
// - framing select 2'b10 gives 8-bit asynchronous frames.
// - 8-bit frames carry parity only when enabled; polarity picks even or odd.
// - framing select 2'b11 gives 9-bit frames, never any parity.
// - ninth transmit bit from mode register; received ninth bit into control register.
// - with wakeup gate set in 9-bit mode only ninth-bit-one frames interrupt.
// - receive errors sit in control register bits masked by 8'b00011100.
// - modulator sends a short high pulse per 0 bit, low for 1 bits.
// - pulse width choice 0 gives 3/16 bit, 1 gives 1/16 bit.
// - demodulator passes 0 only for pulses reaching minimum width, else 1.
// - receive polarity 0 treats high pulses as active, 1 low pulses.
// - disabled infrared transmit or receive ignores its input.
// - width code n qualifies 2(n+1) clocks plus 100 ns; code 0 not allowed, but the code accepts it and qualifies 2 clocks plus 100 ns.
// - the infrared path exists on serial channel zero only.
package usw_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h04;
  localparam logic [4:0] ADDR_BUF = 5'h08;
  localparam logic [4:0] ADDR_IR = 5'h0c;
  localparam logic [4:0] ADDR_BAUD = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  // mode register fields
  localparam int MODE_TB8 = 7;
  localparam int MODE_RXE = 5;
  localparam int MODE_WU = 4;
  localparam int MODE_SM_LO = 2;
  localparam int MODE_SC_LO = 0;
  // control register fields
  localparam int CTRL_RB8 = 7;
  localparam int CTRL_EVEN = 6;
  localparam int CTRL_PE = 5;
  localparam int CTRL_OERR = 4;
  localparam int CTRL_PERR = 3;
  localparam int CTRL_FERR = 2;
  localparam logic [7:0] CTRL_ERR_MASK = 8'h1c;
  // infrared control fields
  localparam int IR_PULSE_WIDTH_CHOICE = 7;
  localparam int IR_RX_PULSE_POLARITY = 6;
  localparam int IR_TXON = 5;
  localparam int IR_RXON = 4;
  localparam logic [7:0] IR_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  localparam logic [1:0] SM_8BIT = 2'b10;
  localparam logic [1:0] SM_9BIT = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // width qualification timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WIDTH_EXTRA_NS = 100;
  localparam int WIDTH_EXTRA_CYC = (WIDTH_EXTRA_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WIDTH_STEP_CYC = 2;
  localparam int OVS = 16;
  typedef struct packed {
    logic [1:0] framing;
    logic parity_on;
    logic parity_odd;
    logic tx_ninth_bit;
  } usw_frame_cfg_t;
  typedef struct packed {
    logic pulse_width_choice;
    logic rx_pulse_polarity;
    logic ir_transmit_on;
    logic ir_receive_on;
    logic [3:0] rx_min_width_code;
  } usw_ir_cfg_t;
  // parity of a byte, xor reduced
  function automatic logic usw_par(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
endpackage

// ---- rtl/usw_irda.sv ----
// usw_irda: infrared modulator and demodulator for serial channel zero.
// assumes tick16 is a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/100ps
module usw_irda (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire usw_pkg::usw_ir_cfg_t cfg,
  input wire logic tick16,
  input wire logic tx_serial,
  input wire logic ir_in_sync,
  output logic ir_out,
  output logic rx_serial
);
  import usw_pkg::*;
  logic [3:0] ph_r, ph_nxt, rph_r, rph_nxt;
  logic ir_out_r, ir_out_nxt;
  logic prev_tx_r, prev_tx_nxt;
  logic [7:0] wcnt_r, wcnt_nxt;
  logic rx_r, rx_nxt;
  logic [7:0] need;
  logic active;

  // phase counter restarts at each bit edge of the serial stream
  always_comb begin
    ph_nxt = ph_r;
    prev_tx_nxt = tx_serial;
    ir_out_nxt = 1'b0;
    if (tx_serial != prev_tx_r) begin
      ph_nxt = 4'h0;
    end else if (tick16) begin
      ph_nxt = ph_r + 4'h1;
    end
    if (cfg.ir_transmit_on && !tx_serial) begin
      ir_out_nxt = cfg.pulse_width_choice ? (ph_nxt == 4'h0) : (ph_nxt < 4'h3);
    end
  end

  // minimum width: 2 clocks per code step plus one step, then the 100 ns allowance
  assign need = 8'(WIDTH_STEP_CYC) * ({4'h0, cfg.rx_min_width_code} + 8'h01) +
    8'(WIDTH_EXTRA_CYC);
  assign active = cfg.rx_pulse_polarity ? !ir_in_sync : ir_in_sync;

  // stretch a qualified pulse to one whole bit so the receiver samples it;
  // own phase, as the transmit phase has no relation to incoming bits
  always_comb begin
    wcnt_nxt = wcnt_r;
    rx_nxt = rx_r;
    rph_nxt = tick16 ? rph_r + 4'h1 : rph_r;
    if (!cfg.ir_receive_on) begin
      wcnt_nxt = 8'h00;
      rx_nxt = 1'b1;
    end else if (active) begin
      if (wcnt_r != 8'hff) wcnt_nxt = wcnt_r + 8'h01;
      if (wcnt_nxt >= need) begin
        rx_nxt = 1'b0;
        rph_nxt = 4'h0;
      end
    end else begin
      wcnt_nxt = 8'h00;
      if (tick16 && rph_r == 4'hf) rx_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ph_r <= 4'h0;
      prev_tx_r <= 1'b1;
      ir_out_r <= 1'b0;
      wcnt_r <= 8'h00;
      rph_r <= 4'h0;
      rx_r <= 1'b1;
    end else begin
      ph_r <= ph_nxt;
      prev_tx_r <= prev_tx_nxt;
      ir_out_r <= ir_out_nxt;
      wcnt_r <= wcnt_nxt;
      rph_r <= rph_nxt;
      rx_r <= rx_nxt;
    end
  end
  assign ir_out = ir_out_r;
  assign rx_serial = rx_r;
endmodule

// ---- rtl/usw_baud.sv ----
// usw_baud: baud rate generator giving a sixteen-times oversampling tick.
// assumes divisor written by software, zero treated as one.
`timescale 1ns/100ps
module usw_baud (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] divisor,
  output logic tick16
);
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  // count down, reload on one or zero
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r - 16'h0001;
    if (cnt_r == 16'h0000 || cnt_r == 16'h0001) begin
      cnt_nxt = divisor;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick16 = tick_r;
endmodule

// ---- rtl/usw_uart.sv ----
// usw_uart: serial channel zero with 8/9-bit asynchronous framing, wakeup
// gating, infrared modem and an AXI4-Lite register slave.
// assumes rxd_pin and ir_rx_pin are asynchronous and synchronised here.
`timescale 1ns/100ps
module usw_uart (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe,
  input wire logic ir_rx_pin,
  output logic ir_tx_out,
  output logic receive_irq,
  output logic transmit_irq
);
  import usw_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01
  } usw_state_t;

  // registers
  logic [7:0] serial_mode_reg_r, serial_mode_reg_nxt;
  logic [7:0] serial_control_reg_r, serial_control_reg_nxt, ctrl_rx_nxt;
  logic [7:0] infrared_control_r, infrared_control_nxt;
  logic [15:0] baud_div_r, baud_div_nxt;
  logic [7:0] rx_buf_r, rx_buf_nxt;
  logic rx_full_r, rx_full_nxt;
  logic open_drain_r, open_drain_nxt;
  // bus state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [4:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // transmitter and receiver
  usw_state_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_bits_r, tx_bits_nxt, tx_ph_r, tx_ph_nxt;
  logic [3:0] rx_bits_r, rx_bits_nxt, rx_ph_r, rx_ph_nxt;
  logic [9:0] rx_sh_r, rx_sh_nxt;
  logic tx_pend_r, tx_pend_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic rx_irq_r, rx_irq_nxt, tx_irq_r, tx_irq_nxt;
  logic [1:0] rxd_sy_r, ir_sy_r;
  logic tick16, ir_rx_serial, ser_in, ser_out;
  usw_frame_cfg_t fcfg;
  usw_ir_cfg_t icfg;
  logic wr_fire, rd_fire, wr_buf, rd_buf, ir_mode;
  logic [3:0] frame_len;

  // two-flop synchronisers for the pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxd_sy_r <= 2'b11;
      ir_sy_r <= 2'b00;
    end else begin
      rxd_sy_r <= {rxd_sy_r[0], rxd_pin};
      ir_sy_r <= {ir_sy_r[0], ir_rx_pin};
    end
  end

  assign fcfg.framing = serial_mode_reg_r[MODE_SM_LO +: 2];
  assign fcfg.parity_on = serial_control_reg_r[CTRL_PE];
  assign fcfg.parity_odd = !serial_control_reg_r[CTRL_EVEN];
  assign fcfg.tx_ninth_bit = serial_mode_reg_r[MODE_TB8];
  assign icfg = infrared_control_r;
  // modem sits in the path only while one of its enables is on
  assign ir_mode = icfg.ir_transmit_on || icfg.ir_receive_on;
  assign ser_in = icfg.ir_receive_on ? ir_rx_serial : rxd_sy_r[1];
  // data bits after start: 8, plus parity or ninth bit
  assign frame_len = (fcfg.framing == SM_9BIT || fcfg.parity_on) ? 4'd9 : 4'd8;

  usw_baud u_baud (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .divisor(baud_div_r),
    .tick16(tick16)
  );

  usw_irda u_irda (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cfg(icfg),
    .tick16(tick16),
    .tx_serial(ser_out),
    .ir_in_sync(ir_sy_r[1]),
    .ir_out(ir_tx_out),
    .rx_serial(ir_rx_serial)
  );

  // axi write and read channel handshakes
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign wr_buf = wr_fire && aw_addr_r == ADDR_BUF && w_strb_r[0];
  assign rd_buf = rd_fire && s_axi_araddr == ADDR_BUF;

  // register file, bus slave and transmit request
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    serial_mode_reg_nxt = serial_mode_reg_r;
    serial_control_reg_nxt = ctrl_rx_nxt;
    infrared_control_nxt = infrared_control_r;
    baud_div_nxt = baud_div_r;
    open_drain_nxt = open_drain_r;
    tx_pend_nxt = tx_pend_r;
    tx_data_nxt = tx_data_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (aw_addr_r)
        ADDR_MODE: if (w_strb_r[0]) serial_mode_reg_nxt = w_data_r[7:0];
        ADDR_CTRL: if (w_strb_r[0]) begin
          // only parity controls are writable; status bits stay hardware-owned
          serial_control_reg_nxt[CTRL_EVEN] = w_data_r[CTRL_EVEN];
          serial_control_reg_nxt[CTRL_PE] = w_data_r[CTRL_PE];
        end
        ADDR_BUF: if (w_strb_r[0]) begin
          tx_data_nxt = w_data_r[7:0];
          tx_pend_nxt = 1'b1;
        end
        ADDR_IR: if (w_strb_r[0]) infrared_control_nxt = w_data_r[7:0];
        ADDR_BAUD: begin
          if (w_strb_r[0]) baud_div_nxt[7:0] = w_data_r[7:0];
          if (w_strb_r[1]) baud_div_nxt[15:8] = w_data_r[15:8];
          if (w_strb_r[2]) open_drain_nxt = w_data_r[16];
        end
        ADDR_STAT: ;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_MODE: rdata_nxt[7:0] = serial_mode_reg_r;
        ADDR_CTRL: rdata_nxt[7:0] = serial_control_reg_r;
        ADDR_BUF: rdata_nxt[7:0] = rx_buf_r;
        ADDR_IR: rdata_nxt[7:0] = infrared_control_r;
        ADDR_BAUD: rdata_nxt[16:0] = {open_drain_r, baud_div_r};
        ADDR_STAT: rdata_nxt[2:0] = {tx_st_r == ST_SHIFT, tx_pend_r, rx_full_r};
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
    if (tx_st_r == ST_IDLE && tx_pend_r && tick16) tx_pend_nxt = wr_buf;
  end

  // transmitter: start, data lsb first, parity or ninth bit, stop
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_bits_nxt = tx_bits_r;
    tx_ph_nxt = tx_ph_r;
    tx_irq_nxt = 1'b0;
    unique case (tx_st_r)
      ST_IDLE: if (tx_pend_r && tick16) begin
        tx_st_nxt = ST_SHIFT;
        tx_ph_nxt = 4'h0;
        tx_bits_nxt = frame_len + 4'd2;
        tx_sh_nxt = {1'b1, tx_data_r[0] ^ 1'b0, 9'h000};
        if (fcfg.framing == SM_9BIT) begin
          tx_sh_nxt = {1'b1, fcfg.tx_ninth_bit, tx_data_r, 1'b0};
        end else if (fcfg.parity_on) begin
          tx_sh_nxt = {1'b1, usw_par(tx_data_r, fcfg.parity_odd), tx_data_r, 1'b0};
        end else begin
          tx_sh_nxt = {2'b11, tx_data_r, 1'b0};
        end
      end
      ST_SHIFT: if (tick16) begin
        tx_ph_nxt = tx_ph_r + 4'h1;
        if (tx_ph_r == 4'hf) begin
          tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
          tx_bits_nxt = tx_bits_r - 4'd1;
          if (tx_bits_r == 4'd1) begin
            tx_st_nxt = ST_IDLE;
            tx_irq_nxt = 1'b1;
          end
        end
      end
      default: tx_st_nxt = ST_IDLE;
    endcase
  end
  assign ser_out = (tx_st_r == ST_SHIFT) ? tx_sh_r[0] : 1'b1;
  // with the modem on, the wire pin idles high
  assign txd_out = ir_mode ? 1'b1 : ser_out;
  assign txd_oe = open_drain_r ? !txd_out : 1'b1;

  // receiver: sample mid-bit, frame check, error flags, wakeup gate
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_bits_nxt = rx_bits_r;
    rx_ph_nxt = rx_ph_r;
    rx_buf_nxt = rx_buf_r;
    rx_full_nxt = rx_full_r;
    rx_irq_nxt = 1'b0;
    ctrl_rx_nxt = serial_control_reg_r;
    if (rd_buf) begin
      rx_full_nxt = 1'b0;
      ctrl_rx_nxt[CTRL_OERR] = 1'b0;
      ctrl_rx_nxt[CTRL_PERR] = 1'b0;
      ctrl_rx_nxt[CTRL_FERR] = 1'b0;
    end
    unique case (rx_st_r)
      ST_IDLE: if (tick16 && !ser_in && serial_mode_reg_r[MODE_RXE]) begin
        rx_st_nxt = ST_SHIFT;
        rx_ph_nxt = 4'h1;
        rx_bits_nxt = frame_len + 4'd2; // start shifts out when frame_len is 9, stop lands in bit 9
      end
      ST_SHIFT: if (tick16) begin
        rx_ph_nxt = rx_ph_r + 4'h1;
        if (rx_ph_r == 4'h7) begin
          rx_sh_nxt = {ser_in, rx_sh_r[9:1]};
          rx_bits_nxt = rx_bits_r - 4'd1;
          if (rx_bits_r == 4'd1) begin
            rx_st_nxt = ST_IDLE;
            // stop bit in rx_sh_nxt[9]; shorter frames left-align below
            if (!(fcfg.framing == SM_9BIT && serial_mode_reg_r[MODE_WU] && !rx_sh_nxt[8])) begin
              rx_irq_nxt = 1'b1;
              rx_full_nxt = 1'b1;
              ctrl_rx_nxt[CTRL_OERR] = rx_full_r;
              ctrl_rx_nxt[CTRL_FERR] = !rx_sh_nxt[9];
              if (frame_len == 4'd9) begin
                rx_buf_nxt = rx_sh_nxt[7:0];
                ctrl_rx_nxt[CTRL_RB8] = rx_sh_nxt[8];
                ctrl_rx_nxt[CTRL_PERR] = fcfg.framing != SM_9BIT &&
                  usw_par(rx_sh_nxt[7:0], fcfg.parity_odd) != rx_sh_nxt[8];
              end else begin
                rx_buf_nxt = rx_sh_nxt[8:1];
                ctrl_rx_nxt[CTRL_PERR] = 1'b0;
              end
            end
          end
        end
      end
      default: rx_st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rresp_r <= 2'b00;
      rdata_r <= 32'h0000_0000;
      serial_mode_reg_r <= MODE_RESET;
      serial_control_reg_r <= CTRL_RESET;
      infrared_control_r <= IR_RESET;
      baud_div_r <= BAUD_RESET;
      open_drain_r <= 1'b0;
      tx_pend_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_st_r <= ST_IDLE;
      tx_sh_r <= 11'h7ff;
      tx_bits_r <= 4'h0;
      tx_ph_r <= 4'h0;
      tx_irq_r <= 1'b0;
      rx_st_r <= ST_IDLE;
      rx_sh_r <= 10'h000;
      rx_bits_r <= 4'h0;
      rx_ph_r <= 4'h0;
      rx_buf_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      serial_mode_reg_r <= serial_mode_reg_nxt;
      serial_control_reg_r <= serial_control_reg_nxt;
      infrared_control_r <= infrared_control_nxt;
      baud_div_r <= baud_div_nxt;
      open_drain_r <= open_drain_nxt;
      tx_pend_r <= tx_pend_nxt;
      tx_data_r <= tx_data_nxt;
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_bits_r <= tx_bits_nxt;
      tx_ph_r <= tx_ph_nxt;
      tx_irq_r <= tx_irq_nxt;
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_bits_r <= rx_bits_nxt;
      rx_ph_r <= rx_ph_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_full_r <= rx_full_nxt;
      rx_irq_r <= rx_irq_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign receive_irq = rx_irq_r;
  assign transmit_irq = tx_irq_r;
endmodule

// ---- tb/usw_chk.sv ----
// usw_chk: port checker for usw_uart, bound below.
// assumes one clock and an async active-low reset.
`timescale 1ns/100ps
module usw_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic ir_tx_out,
  input wire logic receive_irq,
  input wire logic transmit_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // write answer two edges after both items are taken, read answer one edge
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  // no second request accepted while an answer waits
  property p_wr_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_ref: assert property (p_wr_ref) else $error("write taken during response");
  property p_rd_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rd_ref: assert property (p_rd_ref) else $error("read taken during response");
  // events are single-cycle pulses; transmit ends on the idle level
  property p_rx_pulse; receive_irq |=> !receive_irq; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive event too long");
  property p_tx_end; transmit_irq |-> txd_out ##1 !transmit_irq; endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit event bad");
  // a driven low is always enabled, so open-drain links still pull down
  property p_od; !txd_out |-> txd_oe; endproperty
  a_od: assert property (p_od) else $error("low level not driven");
  property p_ir_quiet; ir_tx_out |-> txd_out; endproperty
  a_ir_quiet: assert property (p_ir_quiet) else $error("wire active during infrared");
  cover property (receive_irq);
  cover property (transmit_irq);
  cover property (ir_tx_out);
endmodule
bind usw_uart usw_chk i_usw_chk (.*);

// ---- tb/usw_peer.sv ----
// usw_peer: far-side sender on the serial wire and the infrared input.
// assumes BIT clocks per bit; the caller builds each frame.
`timescale 1ns/100ps
module usw_peer #(
  parameter int BIT = 128
) (
  input wire logic clk_sys,
  output logic rxd_pin,
  output logic ir_rx_pin
);
  // wire idles high, infrared idles inactive
  initial begin
    rxd_pin = 1'b1;
    ir_rx_pin = 1'b0;
  end
  // set the infrared idle level before the receiver is enabled
  task automatic idle(input logic pol);
    ir_rx_pin <= pol;
  endtask
  // lsb first; on infrared each 0 becomes one active pulse of pw clocks
  task automatic frame(input logic [10:0] b, input int n, input logic ir, input logic pol,
                       input int pw);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < BIT; c++) begin
        @(posedge clk_sys);
        if (ir) ir_rx_pin <= (!b[i] && c < pw) ? !pol : pol;
        else rxd_pin <= b[i];
      end
    end
  endtask
endmodule

// ---- tb/tb.sv ----
// tb: self-checking bench for usw_uart with a far-side serial peer.
// assumes a 250 MHz clock and the register map of usw_pkg.
`timescale 1ns/100ps
module tb;
  import usw_pkg::*;
  localparam int DIV = 8;
  localparam int BIT = 16 * DIV;
  localparam int SLOW_DIV = 407; // bit rate just under 38.4 kbps
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rxd_pin, ir_rx_pin, txd_out, txd_oe, ir_tx_out, receive_irq, transmit_irq;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int nrx = 0;
  int nhi = 0;
  usw_uart i_usw_uart (.*);
  usw_peer #(.BIT(BIT)) i_usw_peer (.*);
  always #2 clk_sys = ~clk_sys;
  // count receive events and infrared high cycles; cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (receive_irq === 1'b1) nrx <= nrx + 1;
    if (ir_tx_out === 1'b1) nhi <= nhi + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    chk("rresp", er, s_axi_rresp);
    chk("rdata", e, s_axi_rdata & m);
    s_axi_rready <= 1'b0;
  endtask
  // frame: start, pd lsb first, stop; then one idle bit
  task automatic send(input logic [8:0] pd, input int n, input logic ir, input logic pol,
                      input int pw);
    i_usw_peer.frame({1'b1, pd, 1'b0}, n, ir, pol, pw);
    repeat (BIT) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    axi_rd(ADDR_MODE, {24'h0, MODE_RESET}, 32'hff, RESP_OKAY);
    axi_rd(ADDR_IR, {24'h0, IR_RESET}, 32'hff, RESP_OKAY);
    axi_rd(ADDR_BAUD, {16'h0, BAUD_RESET}, 32'hffff, RESP_OKAY);
    axi_wr(5'h18, 32'hff, RESP_SLVERR);
    axi_rd(5'h18, 32'h0, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_IR, 32'h87, RESP_OKAY);
    axi_rd(ADDR_IR, 32'h87, 32'hff, RESP_OKAY);
    axi_wr(ADDR_IR, 32'h0, RESP_OKAY);
    axi_wr(ADDR_BAUD, 32'(DIV), RESP_OKAY);
  endtask
  // odd and even parity, each good and corrupted
  task automatic t_rx8();
    logic [7:0] d;
    logic p;
    axi_wr(ADDR_MODE, 32'h28, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      d = 8'h5a + 8'(k);
      p = (^d) ^ !k[0] ^ k[1];
      axi_wr(ADDR_CTRL, {25'h0, k[0], 1'b1, 5'h0}, RESP_OKAY);
      send({p, d}, 11, 1'b0, 1'b0, 0);
      axi_rd(ADDR_CTRL, {28'h0, k[1], 3'h0}, {24'h0, CTRL_ERR_MASK}, RESP_OKAY);
      axi_rd(ADDR_BUF, {24'h0, d}, 32'hff, RESP_OKAY);
    end
  endtask
  // gated slave ignores data, takes the select frame, then data once ungated
  task automatic t_wake();
    int n0;
    axi_wr(ADDR_MODE, 32'h3c, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) axi_wr(ADDR_MODE, 32'h2c, RESP_OKAY);
      n0 = nrx;
      send({k == 1, 8'h30 + 8'(k)}, 11, 1'b0, 1'b0, 0);
      chk("rx_irq", n0 + (k > 0), nrx);
      if (k > 0) begin
        axi_rd(ADDR_CTRL, {24'h0, k == 1, 7'h0}, 32'h80, RESP_OKAY);
        axi_rd(ADDR_BUF, 32'h30 + k, 32'hff, RESP_OKAY);
      end
    end
  endtask
  // 9-bit with ninth bit, 8-bit odd parity, 8-bit plain; sample mid-bit
  task automatic t_tx();
    logic [10:0] e;
    int t;
    for (int k = 0; k < 3; k++) begin
      axi_wr(ADDR_CTRL, k == 1 ? 32'h20 : 32'h0, RESP_OKAY);
      axi_wr(ADDR_MODE, k == 0 ? 32'h8c : 32'h09, RESP_OKAY);
      e = {1'b1, k == 1 ? ~^8'hb4 : 1'b1, 8'hb4, 1'b0};
      axi_wr(ADDR_BUF, 32'hb4, RESP_OKAY);
      t = 0;
      while (txd_out !== 1'b0 && t < BIT) begin
        @(posedge clk_sys);
        t++;
      end
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 10 + (k < 2); i++) begin
        chk("txd_bit", e[i], txd_out);
        repeat (BIT) @(posedge clk_sys);
      end
    end
  endtask
  // 0x0f: five 3-tick pulses; 0xff at the slow rate: one 1-tick pulse; off: none
  task automatic t_irtx();
    logic [7:0] tc [3] = '{8'h20, 8'ha0, 8'h00};
    int e [3] = '{15 * DIV, SLOW_DIV, 0};
    int h0;
    for (int k = 0; k < 3; k++) begin
      axi_wr(ADDR_IR, {24'h0, tc[k] & 8'hcf}, RESP_OKAY);
      axi_wr(ADDR_IR, {24'h0, tc[k]}, RESP_OKAY);
      if (k == 1) axi_wr(ADDR_BAUD, SLOW_DIV, RESP_OKAY);
      h0 = nhi;
      axi_wr(ADDR_BUF, k == 1 ? 32'hff : 32'h0f, RESP_OKAY);
      repeat (k == 1 ? 32 * SLOW_DIV : 0) @(posedge clk_sys);
      axi_wr(ADDR_BAUD, DIV, RESP_OKAY);
      repeat (12 * BIT) @(posedge clk_sys);
      chk("ir_high", e[k], nhi - h0);
    end
  endtask
  // both polarities, two width codes, a short pulse and a disabled receiver
  task automatic t_irrx();
    logic [7:0] rc [4] = '{8'h11, 8'h52, 8'h11, 8'h01};
    int pw [4] = '{32, 32, 22, 32};
    int n0;
    axi_wr(ADDR_MODE, 32'h29, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      axi_wr(ADDR_IR, {24'h0, rc[k] & 8'hcf}, RESP_OKAY);
      i_usw_peer.idle(rc[k][6]);
      axi_wr(ADDR_IR, {24'h0, rc[k]}, RESP_OKAY);
      n0 = nrx;
      send({1'b1, 8'ha6}, 10, 1'b1, rc[k][6], pw[k]);
      chk("rx_irq", n0 + (k < 2), nrx);
      if (k < 2) axi_rd(ADDR_BUF, 32'ha6, 32'hff, RESP_OKAY);
    end
    axi_wr(ADDR_IR, 32'h0, RESP_OKAY);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_rx8();
    t_wake();
    t_tx();
    t_irtx();
    t_irrx();
    wrap_up();
  end
endmodule
